// ---- pdc_ctrl.sv ----
// Control-bit logic of a serially programmed PLL clock synthesizer
`timescale 1ns/10ps

module pdc_ctrl import pdc_pkg::*; #(
    parameter int REF_W = 7,
    parameter int FB_W = 6,
    parameter int SEC_W = 9
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ser_data,
    input wire logic i_ser_shift,
    input wire logic i_ser_load,
    input wire logic i_vco_en,
    input wire logic i_ref_en,
    input wire logic i_blank,
    input wire logic i_ext_fbk,
    input wire logic i_aux_mode,
    input wire logic i_aux_clk,
    input wire logic i_aux_n1,
    input wire logic [REF_W-1:0] i_ref_div_val,
    input wire logic [FB_W-1:0] i_fb_div_val,
    input wire logic [SEC_W-1:0] i_second_div_val,
    output logic o_clk_p,
    output logic o_clk_n,
    output logic o_load,
    output logic o_second_div,
    output logic o_pd_up,
    output logic o_pd_dn,
    output logic o_pd_oe_n,
    output logic [3:0] o_first_ratio,
    output logic o_lockout
);

    initial begin
        if (REF_W < 1 || FB_W < 1 || SEC_W < 1 || SEC_W > 16) begin
            $error("pdc_ctrl: counter widths out of range");
        end
    end

    // Serial shift register and applied program word
    logic [PDC_WORD_BITS-1:0] shift_q;
    logic [PDC_WORD_BITS-1:0] shift_d;
    logic [PDC_WORD_BITS-1:0] word_q;
    logic [PDC_WORD_BITS-1:0] word_d;
    logic lock_q;
    logic lock_d;

    wire trap_hit = shift_q[PDC_POS_LOCKOUT];
    wire load_ok = i_ser_load & ~lock_q;

    // Bit 1 is shifted in first and ends at the low end
    assign shift_d = i_ser_shift ?
        {i_ser_data, shift_q[PDC_WORD_BITS-1:1]} : shift_q;
    assign lock_d = lock_q | (load_ok & trap_hit);
    assign word_d = (load_ok & ~trap_hit) ? shift_q : word_q;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            shift_q <= '0;
            word_q <= PDC_WORD_RST;
            lock_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            word_q <= word_d;
            lock_q <= lock_d;
        end
    end

    wire [2:0] first_sel = word_q[PDC_POS_FIRST_SEL +: 3];
    wire cnt_clear = word_q[PDC_POS_CNT_CLEAR];
    wire clk_hold = word_q[PDC_POS_CLK_HOLD];
    wire ref_bypass = word_q[PDC_POS_REF_BYPASS];
    wire alt_loop = word_q[PDC_POS_ALT_LOOP];
    wire shift_gate = word_q[PDC_POS_SHIFT_GATE];
    wire ext_fbk_en = word_q[PDC_POS_EXT_FBK];
    wire pd_rst_en = word_q[PDC_POS_PD_RST];

    // A locked device stops every counter
    wire run = ~lock_q;
    wire src_en = run & (ref_bypass ? i_ref_en : i_vco_en);

    wire [3:0] ratio = pdc_first_ratio(first_sel);
    wire [3:0] half = {1'b0, ratio[3:1]};

    // First divider: square wave, high for the first half of its period
    logic [3:0] first_cnt_q;
    logic [3:0] first_cnt_d;
    logic first_out_q;
    logic load_raw_q;

    wire first_wrap = src_en & (first_cnt_q >= ratio - 4'h1);
    assign first_cnt_d = !src_en ? first_cnt_q :
        (first_wrap ? 4'h0 : first_cnt_q + 4'h1);
    wire first_out_d = (first_cnt_d < half);
    // Auxiliary mode drives the load path from the software bit instead
    wire load_raw_d = i_aux_mode ? i_aux_n1 : first_out_d;
    // Second divider stepped by load edge
    wire load_rise = run & load_raw_d & ~load_raw_q;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            first_cnt_q <= 4'h0;
            first_out_q <= 1'b1;
            load_raw_q <= 1'b1;
        end else begin
            first_cnt_q <= first_cnt_d;
            first_out_q <= first_out_d;
            load_raw_q <= run ? load_raw_d : load_raw_q;
        end
    end

    // Second divider: modulus is the value, 0 and 1 both pass every edge
    logic [SEC_W-1:0] sec_cnt_q;
    logic [SEC_W-1:0] sec_cnt_d;
    logic sec_out_q;

    wire sec_tc = load_rise &
        ({1'b0, sec_cnt_q} + 1'b1 >= {1'b0, i_second_div_val});
    assign sec_cnt_d = cnt_clear ? '0 :
        (sec_tc ? '0 : (load_rise ? sec_cnt_q + 1'b1 : sec_cnt_q));
    wire sec_out_d = cnt_clear ? 1'b0 : (sec_tc ? ~sec_out_q : sec_out_q);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sec_cnt_q <= '0;
            sec_out_q <= 1'b0;
        end else begin
            sec_cnt_q <= sec_cnt_d;
            sec_out_q <= sec_out_d;
        end
    end

    // Reference divider and internal prescaler, modulus value plus one
    logic [REF_W-1:0] ref_cnt_q;
    logic [FB_W-1:0] pre_cnt_q;

    wire ref_go = run & i_ref_en;
    wire pre_go = run & i_vco_en;
    wire ref_tc = ref_go & (ref_cnt_q == '0);
    wire pre_tc = pre_go & (pre_cnt_q == '0);
    wire [REF_W-1:0] ref_cnt_d = cnt_clear ? i_ref_div_val :
        (ref_tc ? i_ref_div_val : (ref_go ? ref_cnt_q - 1'b1 : ref_cnt_q));
    wire [FB_W-1:0] pre_cnt_d = cnt_clear ? i_fb_div_val :
        (pre_tc ? i_fb_div_val : (pre_go ? pre_cnt_q - 1'b1 : pre_cnt_q));

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ref_cnt_q <= '0;
            pre_cnt_q <= '0;
        end else begin
            ref_cnt_q <= ref_cnt_d;
            pre_cnt_q <= pre_cnt_d;
        end
    end

    // Feedback source, external pin has priority over the loop choice
    logic ext_fbk_q;
    wire ext_rise = run & i_ext_fbk & ~ext_fbk_q;
    wire loop_fb = alt_loop ? sec_tc : pre_tc;
    wire fb_pulse = ext_fbk_en ? ext_rise : loop_fb;

    wire pd_reset = cnt_clear | (pd_rst_en & i_blank) | lock_q;

    pdc_pd_state_t pd_q;
    pdc_pd_state_t pd_d;

    always_comb begin
        pd_d = pd_q;
        case (pd_q)
            PDC_PD_IDLE: begin
                if (ref_tc && !fb_pulse) begin
                    pd_d = PDC_PD_UP;
                end else if (fb_pulse && !ref_tc) begin
                    pd_d = PDC_PD_DN;
                end
            end
            PDC_PD_UP: begin
                if (fb_pulse) begin
                    pd_d = PDC_PD_IDLE;
                end
            end
            PDC_PD_DN: begin
                if (ref_tc) begin
                    pd_d = PDC_PD_IDLE;
                end
            end
            default: pd_d = PDC_PD_IDLE;
        endcase
        if (pd_reset) begin
            pd_d = PDC_PD_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pd_q <= PDC_PD_IDLE;
            ext_fbk_q <= 1'b0;
        end else begin
            pd_q <= pd_d;
            ext_fbk_q <= i_ext_fbk;
        end
    end

    // Differential clock with hold and synchronised restart
    logic clk_ph_q;
    logic hold_wait_q;

    wire hold_wait_d = clk_hold | (hold_wait_q & ~load_rise);
    wire held = clk_hold | hold_wait_q;
    // Restarting from the high phase avoids a runt pulse at release
    wire clk_ph_d = held ? 1'b1 : (src_en ? ~clk_ph_q : clk_ph_q);
    wire norm_p = i_aux_mode ? i_aux_clk : clk_ph_d;
    wire clk_p_d = lock_q ? 1'b0 : (held ? 1'b1 : norm_p);
    wire clk_n_d = lock_q ? 1'b1 : (held ? 1'b0 : ~norm_p);

    wire gate_off = shift_gate & i_blank;
    wire load_d = ~gate_off & ~lock_q & load_raw_d;
    wire second_d = ~gate_off & ~lock_q & sec_out_d;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            clk_ph_q <= 1'b1;
            hold_wait_q <= 1'b0;
            o_clk_p <= 1'b0;
            o_clk_n <= 1'b1;
            o_load <= 1'b0;
            o_second_div <= 1'b0;
        end else begin
            clk_ph_q <= clk_ph_d;
            hold_wait_q <= hold_wait_d;
            o_clk_p <= clk_p_d;
            o_clk_n <= clk_n_d;
            o_load <= load_d;
            o_second_div <= second_d;
        end
    end

    // Detector pins float while cleared or locked out
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_pd_up <= 1'b0;
            o_pd_dn <= 1'b0;
            o_pd_oe_n <= 1'b1;
            o_first_ratio <= PDC_RATIO_4;
            o_lockout <= 1'b0;
        end else begin
            o_pd_up <= (pd_d == PDC_PD_UP);
            o_pd_dn <= (pd_d == PDC_PD_DN);
            o_pd_oe_n <= cnt_clear | lock_q;
            o_first_ratio <= ratio;
            o_lockout <= lock_d;
        end
    end

endmodule : pdc_ctrl

// ---- pdc_ctrl_assertions.sv ----
// Checker for the PLL divider control bits block
`timescale 1ns/10ps
module pdc_ctrl_assertions (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ser_data,
    input wire logic i_ser_shift,
    input wire logic i_ser_load,
    input wire logic i_blank,
    input wire logic o_clk_p,
    input wire logic o_clk_n,
    input wire logic o_load,
    input wire logic o_second_div,
    input wire logic o_pd_up,
    input wire logic o_pd_dn,
    input wire logic o_pd_oe_n,
    input wire logic [3:0] o_first_ratio,
    input wire logic o_lockout
);
    logic [11:0] sh_q;
    logic [11:0] word_q;
    wire pdr = word_q[11] & i_blank;
    // Shadow of the program word, so the clear, hold, blank and detector-reset checks see the applied bits
    always_ff @(posedge i_clk) begin
        if (!i_nrst) word_q <= 12'h001;
        else if (i_ser_load && !o_lockout && !sh_q[4]) word_q <= sh_q;
        if (i_ser_shift) sh_q <= {i_ser_data, sh_q[11:1]};
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence trap_load;
        i_ser_load && sh_q[4] && !o_lockout;
    endsequence
    sequence locked_two;
        o_lockout && $past(o_lockout);
    endsequence
    reset_vals_a: assert property (
        $rose(i_nrst) |-> o_first_ratio == 4'h4 && !o_lockout)
        else $error("reset values wrong");
    lock_rise_a: assert property (
        trap_load |=> o_lockout) else $error("lockout not set");
    lock_quiet_a: assert property (
        locked_two |-> !o_clk_p && o_clk_n && !o_load && o_pd_oe_n)
        else $error("device runs while locked");
    lock_ignore_a: assert property (
        o_lockout |=> o_lockout && $stable(o_first_ratio))
        else $error("load taken while locked");
    clear_float_a: assert property (
        word_q[5] && $past(word_q[5]) |=> o_pd_oe_n && !o_pd_up && !o_pd_dn)
        else $error("detector active under clear");
    hold_high_a: assert property (
        word_q[6] && $past(word_q[6]) |-> o_clk_p && !o_clk_n)
        else $error("clock not held");
    blank_gate_a: assert property (
        word_q[9] && i_blank |=> !o_load && !o_second_div)
        else $error("blank did not gate load");
    pd_block_a: assert property (
        pdr && $past(pdr) |=> !o_pd_up && !o_pd_dn)
        else $error("detector active while blanked");
endmodule : pdc_ctrl_assertions
bind pdc_ctrl pdc_ctrl_assertions u_chk (.i_clk, .i_nrst, .i_ser_data,
    .i_ser_shift, .i_ser_load, .i_blank, .o_clk_p, .o_clk_n, .o_load,
    .o_second_div, .o_pd_up, .o_pd_dn, .o_pd_oe_n, .o_first_ratio, .o_lockout);

// ---- pdc_host.sv ----
// Host model that loads the serial program word
`timescale 1ns/10ps
module pdc_host (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic i_trap,
    input wire logic i_slow,
    input wire logic [11:0] i_word,
    output logic o_ser_data,
    output logic o_ser_shift,
    output logic o_ser_load,
    output logic o_busy
);
    initial begin
        o_ser_data = 1'b0;
        o_ser_shift = 1'b0;
        o_ser_load = 1'b0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                o_busy = 1'b1;
                for (int i = 0; i < 12; i++) begin
                    #1;
                    o_ser_shift = 1'b1;
                    o_ser_data = (i == 4) ? i_trap : i_word[i];
                    @(posedge i_clk);
                    if (i_slow) begin
                        #1;
                        o_ser_shift = 1'b0;
                        // Idle data flips so a stale bit is never mistaken
                        o_ser_data = ~o_ser_data;
                        @(posedge i_clk);
                    end
                end
                #1;
                o_ser_shift = 1'b0;
                o_ser_load = 1'b1;
                o_ser_data = ~o_ser_data;
                @(posedge i_clk);
                #1;
                o_ser_load = 1'b0;
                o_busy = 1'b0;
            end
        end
    end
endmodule : pdc_host

// ---- pdc_pkg.sv ----
// Constants and types for the PLL divider control bits block
package pdc_pkg;

    // Program word positions, counted from bit 1 of the serial stream
    localparam int PDC_WORD_BITS = 12;
    localparam int PDC_POS_FIRST_SEL = 0;
    localparam int PDC_POS_SPARE = 3;
    localparam int PDC_POS_LOCKOUT = 4;
    localparam int PDC_POS_CNT_CLEAR = 5;
    localparam int PDC_POS_CLK_HOLD = 6;
    localparam int PDC_POS_REF_BYPASS = 7;
    localparam int PDC_POS_ALT_LOOP = 8;
    localparam int PDC_POS_SHIFT_GATE = 9;
    localparam int PDC_POS_EXT_FBK = 10;
    localparam int PDC_POS_PD_RST = 11;

    // Values after reset
    localparam logic [2:0] PDC_FIRST_SEL_RST = 3'h1;
    localparam logic [11:0] PDC_WORD_RST = 12'h001;

    // First divider ratios
    localparam logic [3:0] PDC_RATIO_4 = 4'h4;
    localparam logic [3:0] PDC_RATIO_5 = 4'h5;
    localparam logic [3:0] PDC_RATIO_6 = 4'h6;
    localparam logic [3:0] PDC_RATIO_8 = 4'h8;
    localparam logic [3:0] PDC_RATIO_10 = 4'hA;

    typedef enum logic [1:0] {
        PDC_PD_IDLE,
        PDC_PD_UP,
        PDC_PD_DN
    } pdc_pd_state_t;

    // Select code to first divider ratio; code 000 is unlisted, taken as 4
    function automatic logic [3:0] pdc_first_ratio(input logic [2:0] sel);
        logic [3:0] r;
        r = PDC_RATIO_4;
        case (sel)
            3'h3: r = PDC_RATIO_5;
            3'h4: r = PDC_RATIO_6;
            3'h5, 3'h6: r = PDC_RATIO_8;
            3'h7: r = PDC_RATIO_10;
            default: r = PDC_RATIO_4;
        endcase
        return r;
    endfunction : pdc_first_ratio

endpackage : pdc_pkg

// ---- tb.sv ----
// Self-checking bench for the PLL divider control bits block
`timescale 1ns/10ps
module tb;
    logic i_clk, i_nrst, i_blank, go, trap, slow, vco_on, ref_on;
    logic vco_en, ref_en, p;
    logic [1:0] ph;
    logic [11:0] word;
    logic [3:0] tbl [8];
    int n_fail, comparisons;
    wire sd, ss, sl, busy, cp, cn, ld, sec, up, dn, oe_n, lock;
    wire [3:0] ratio;
    pdc_host host (.i_clk, .i_go(go), .i_trap(trap), .i_slow(slow),
        .i_word(word), .o_ser_data(sd), .o_ser_shift(ss), .o_ser_load(sl),
        .o_busy(busy));
    pdc_ctrl uut (.i_clk, .i_nrst, .i_ser_data(sd), .i_ser_shift(ss),
        .i_ser_load(sl), .i_vco_en(vco_en), .i_ref_en(ref_en), .i_blank,
        .i_ext_fbk(ph[1]), .i_aux_mode(1'b0), .i_aux_clk(ph[0]),
        .i_aux_n1(ph[1]), .i_ref_div_val(7'h03), .i_fb_div_val(6'h05),
        .i_second_div_val(9'h002), .o_clk_p(cp), .o_clk_n(cn), .o_load(ld),
        .o_second_div(sec), .o_pd_up(up), .o_pd_dn(dn), .o_pd_oe_n(oe_n),
        .o_first_ratio(ratio), .o_lockout(lock));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // Oscillator pulses every other cycle, reference every fourth
    always @(posedge i_clk) begin
        #1;
        ph = ph + 2'h1;
        vco_en = vco_on & ph[0];
        ref_en = ref_on & (ph == 2'h0);
    end
    task print_verdict;
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc
    task load(input logic [11:0] w, input logic t);
        int k;
        word = w;
        trap = t;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        for (k = 0; busy === 1'b1 && k < 60; k++) cyc(1);
        if (k == 60) begin
            n_fail++;
            print_verdict;
        end
        cyc(3);
    endtask : load
    // Bounded wait for the positive clock output to change
    task tog(input int lim);
        p = cp;
        for (int k = 0; cp === p && k < lim; k++) cyc(1);
        chk({3'h0, cp}, {3'h0, ~p});
    endtask : tog
    task t_ratio;
        tbl = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h6, 4'h8, 4'h8, 4'hA};
        for (int c = 0; c < 8; c++) begin
            slow = c[0];
            load({9'h000, c[2:0]}, 1'b0);
            chk(ratio, tbl[c]);
        end
        slow = 1'b0;
    endtask : t_ratio
    task t_clear;
        load(12'h021, 1'b0);
        chk({1'b0, up, dn, oe_n}, 4'h1);
        load(12'h001, 1'b0);
        chk({3'h0, oe_n}, 4'h0);
    endtask : t_clear
    task t_hold;
        load(12'h041, 1'b0);
        repeat (8) begin
            chk({2'h0, cp, cn}, 4'h2);
            cyc(1);
        end
        load(12'h001, 1'b0);
        tog(40);
    endtask : t_hold
    task t_bypass;
        load(12'h081, 1'b0);
        p = cp;
        repeat (10) begin
            chk({3'h0, cp}, {3'h0, p});
            cyc(1);
        end
        ref_on = 1'b1;
        tog(20);
        ref_on = 1'b0;
    endtask : t_bypass
    task t_blank;
        load(12'hA01, 1'b0);
        i_blank = 1'b1;
        cyc(2);
        repeat (8) begin
            chk({ld, sec, up, dn}, 4'h0);
            cyc(1);
        end
        i_blank = 1'b0;
    endtask : t_blank
    // Feedback source: ref events are off, so any feedback pulse gives down
    task t_fb;
        vco_on = 1'b0;
        load(12'h021, 1'b0);
        load(12'h001, 1'b0);
        cyc(16);
        chk({2'h0, up, dn}, 4'h0);
        load(12'h401, 1'b0);
        cyc(4);
        chk({2'h0, up, dn}, 4'h1);
        vco_on = 1'b1;
        load(12'h021, 1'b0);
        load(12'h001, 1'b0);
        cyc(16);
        chk({2'h0, up, dn}, 4'h1);
    endtask : t_fb
    task t_lock;
        load(12'h001, 1'b1);
        chk({3'h0, lock}, 4'h1);
        load(12'h007, 1'b0);
        chk(ratio, 4'h4);
        i_nrst = 1'b0;
        cyc(2);
        i_nrst = 1'b1;
        cyc(1);
        chk({3'h0, lock}, 4'h0);
    endtask : t_lock
    initial begin
        {n_fail, comparisons} = 0;
        {i_nrst, i_blank, go, trap, slow, ref_on, vco_en, ref_en} = 8'h00;
        vco_on = 1'b1;
        ph = 2'h0;
        word = 12'h000;
        cyc(20);
        i_nrst = 1'b1;
        chk({ratio[2:0], lock}, 4'h8);
        t_ratio;
        t_clear;
        t_hold;
        t_bypass;
        t_blank;
        t_fb;
        t_lock;
        print_verdict;
    end
endmodule : tb
